// file: shared/dsw_defines.vh
/*
  Constants for the serial write port of the 12-bit converter:
  word layout, mode codes, reset values and wake-up timing.
  Assumes a 10 MHz core clock; included by the design file.
*/
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define DSW_WORD_BITS      16
`define DSW_MODE_HI_POS    13
`define DSW_MODE_LO_POS    12
`define DSW_VALUE_MSB      11
`define DSW_VALUE_BITS     12
`define DSW_CNT_BITS       5

// ----------------------------------------------------------------
// mode codes and reset values
// ----------------------------------------------------------------
`define DSW_MODE_NORMAL    2'h0
`define DSW_MODE_PD_1K     2'h1
`define DSW_MODE_PD_100K   2'h2
`define DSW_MODE_PD_HIZ    2'h3
`define DSW_VALUE_RESET    12'h000
`define DSW_MODE_RESET     2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DSW_CLK_PERIOD_NS  100
`define DSW_WAKE_UP_US     39
// longest wake-up rounded up to whole cycles
`define DSW_WAKE_CYCLES    ((`DSW_WAKE_UP_US * 1000 + `DSW_CLK_PERIOD_NS - 1) / `DSW_CLK_PERIOD_NS)

`endif

// file: hdl/dsw_serial_write_port.v
/*
  Serial write port of a 12-bit voltage-output converter: frame
  select, serial clock and data are sampled by the core clock, a
  16-bit word is shifted MSB first and committed on the 16th falling
  serial clock edge. Assumes the serial clock is well below a fifth
  of the core clock so each level is seen for at least two cycles.
*/
`include "dsw_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module dsw_serial_write_port #(
  parameter WAKE_CYCLES = `DSW_WAKE_CYCLES
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        frameSelN,
  input  wire        serialClk,
  input  wire        serialData,
  output reg  [11:0] dacValue_q,
  output reg  [1:0]  powerMode_q,
  output reg         poweredDown_q,
  output reg         outputValid_q,
  output reg         commitPulse_q
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] selSync_q;
  reg [1:0] sclkSync_q;
  reg [1:0] dataSync_q;
  reg       selPrev_q;
  reg       sclkPrev_q;

  // two flops per pin, then one more stage for edge detection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      selSync_q  <= 2'h3;
      sclkSync_q <= 2'h0;
      dataSync_q <= 2'h0;
      selPrev_q  <= 1'b1;
      sclkPrev_q <= 1'b0;
    end else begin
      selSync_q  <= {selSync_q[0], frameSelN};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      dataSync_q <= {dataSync_q[0], serialData};
      selPrev_q  <= selSync_q[1];
      sclkPrev_q <= sclkSync_q[1];
    end
  end

  wire selFall  = selPrev_q & ~selSync_q[1];
  wire selHigh  = selSync_q[1];
  wire sclkFall = sclkPrev_q & ~sclkSync_q[1];

  // ----------------------------------------------------------------
  // shift register and frame control
  // ----------------------------------------------------------------
  reg [15:0] shift_q;
  reg [4:0]  bitCnt_q;
  reg        active_q;
  wire [15:0] word = {shift_q[14:0], dataSync_q[1]};
  wire lastBit = active_q & sclkFall & (bitCnt_q == 5'h0f);
  reg [15:0] wakeCnt_q;

  // select high clears the partial word, only a fresh fall rearms
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q  <= 16'h0000;
      bitCnt_q <= 5'h00;
      active_q <= 1'b0;
    end else if (selHigh) begin
      shift_q  <= 16'h0000;
      bitCnt_q <= 5'h00;
      active_q <= 1'b0;
    end else if (selFall) begin
      shift_q  <= 16'h0000;
      bitCnt_q <= 5'h00;
      active_q <= 1'b1;
    end else if (active_q && sclkFall) begin
      shift_q  <= word;
      bitCnt_q <= bitCnt_q + 5'h01;
      if (lastBit)
        active_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // committed state and wake-up timing
  // ----------------------------------------------------------------
  // the value survives power-down; a normal-mode word loads its own new value
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dacValue_q    <= `DSW_VALUE_RESET;
      powerMode_q   <= `DSW_MODE_RESET;
      poweredDown_q <= 1'b0;
      outputValid_q <= 1'b0;
      commitPulse_q <= 1'b0;
      wakeCnt_q     <= 16'h0000;
    end else begin
      commitPulse_q <= lastBit;
      if (lastBit) begin
        // power-down words leave the held value alone
        if (word[`DSW_MODE_HI_POS:`DSW_MODE_LO_POS] == `DSW_MODE_NORMAL)
          dacValue_q  <= word[`DSW_VALUE_MSB:0];
        powerMode_q   <= word[`DSW_MODE_HI_POS:`DSW_MODE_LO_POS];
        poweredDown_q <= (word[`DSW_MODE_HI_POS:`DSW_MODE_LO_POS] != `DSW_MODE_NORMAL);
        if (poweredDown_q && word[`DSW_MODE_HI_POS:`DSW_MODE_LO_POS] == `DSW_MODE_NORMAL) begin
          outputValid_q <= 1'b0;
          wakeCnt_q     <= WAKE_CYCLES[15:0];
        end else begin
          outputValid_q <= (word[`DSW_MODE_HI_POS:`DSW_MODE_LO_POS] == `DSW_MODE_NORMAL)
                           && (wakeCnt_q == 16'h0000);
        end
      end else if (wakeCnt_q != 16'h0000) begin
        wakeCnt_q <= wakeCnt_q - 16'h0001;
        outputValid_q <= (wakeCnt_q == 16'h0001) && !poweredDown_q;
      end
    end
  end

endmodule

`default_nettype wire

// file: dv/dsw_host_model.sv
/* host side of the port: drives select, serial clock and data; the bench calls send */
`timescale 1ns/100ps
`default_nettype none
module dsw_host_model (
  output logic frameSelN,
  output logic serialClk,
  output logic serialData
);
  // idle with clock stopped, select and data parked low
  initial begin
    frameSelN = 1'b0;
    serialClk = 1'b0;
    serialData = 1'b0;
  end
  // new frame on select fall, msb first, data moves on rises
  task send(input logic [15:0] w, input int n, input logic newFrame);
    if (newFrame) begin
      frameSelN = 1'b1;
      #400 frameSelN = 1'b0;
      #400;
    end
    for (int i = 0; i < n; i++) begin
      serialClk = 1'b1;
      serialData = w[15-i];
      #400 serialClk = 1'b0;
      #400;
    end
    // select stays low after the word, data parked low
    serialData = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/dsw_port_assertions.sv
/* checker on the port pins; assumes one clock domain with async rst */
`timescale 1ns/100ps
`default_nettype none
module dsw_port_assertions #(parameter WAKE_CYCLES = 4) (
  input wire logic        clk, rst, frameSelN, serialClk, serialData,
  input wire logic [11:0] dacValue_q,
  input wire logic [1:0]  powerMode_q,
  input wire logic        poweredDown_q, outputValid_q, commitPulse_q
);
  localparam int WAKE_MAX = WAKE_CYCLES;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_pd_flag: assert property (poweredDown_q == (powerMode_q != 2'h0)) else $error("pd flag");
  chk_pulse_once: assert property (commitPulse_q |=> !commitPulse_q) else $error("pulse long");
  chk_value_commit: assert property ($changed(dacValue_q) |-> commitPulse_q) else $error("value");
  chk_mode_commit: assert property ($changed(powerMode_q) |-> commitPulse_q) else $error("mode");
  chk_valid_normal: assert property (outputValid_q |-> !poweredDown_q) else $error("valid pd");
  chk_wake_delay: assert property ($fell(poweredDown_q) |-> !outputValid_q[*2] ##[1:WAKE_MAX] outputValid_q)
    else $error("wake");
  chk_reset_clear: assert property ($fell(rst) |-> dacValue_q == 12'h000 && !outputValid_q)
    else $error("reset");
  chk_select_low: assert property (commitPulse_q |-> !$past(frameSelN, 5)) else $error("sel");
  cover property ($fell(poweredDown_q));
  cover property (commitPulse_q && powerMode_q == 2'h3);
  cover property ($rose(outputValid_q));
endmodule
bind dsw_serial_write_port dsw_port_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) i_chk (.clk(clk),
  .rst(rst), .frameSelN(frameSelN), .serialClk(serialClk), .serialData(serialData),
  .dacValue_q(dacValue_q), .powerMode_q(powerMode_q), .poweredDown_q(poweredDown_q),
  .outputValid_q(outputValid_q), .commitPulse_q(commitPulse_q));
`default_nettype wire

// file: dv/tb.sv
/* self-checking bench; the host model drives the pins, wake-up shortened to 4 */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, frameSelN, serialClk, serialData, pd, valid, pulse;
  logic [11:0] val, keep = 12'h000;
  logic [1:0] mode;
  logic [15:0] w;
  logic [31:0] rng = 32'd39363;
  int err_count = 0, tests_run = 0, commits = 0;
  always #50 clk = ~clk;
  // count commit pulses so the one-cycle strobe is seen every time
  always @(posedge clk) if (pulse === 1'b1) commits <= commits + 1;
  dsw_host_model i_host (.frameSelN(frameSelN), .serialClk(serialClk), .serialData(serialData));
  dsw_serial_write_port #(.WAKE_CYCLES(4)) i_dut (.clk(clk), .rst(rst), .frameSelN(frameSelN),
    .serialClk(serialClk), .serialData(serialData), .dacValue_q(val), .powerMode_q(mode),
    .poweredDown_q(pd), .outputValid_q(valid), .commitPulse_q(pulse));
  // xorshift word: random don't-care bits and value, chosen mode
  function automatic logic [15:0] word(input logic [1:0] m);
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    word = {rng[15:14], m, rng[11:0]};
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // send, then let the synchronisers and commit settle
  task frame(input logic [15:0] wd, input int n, input logic nf);
    i_host.send(wd, n, nf);
    repeat (8) @(posedge clk);
    #1;
  endtask
  initial begin
    #3000000 err_count++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    check(val, 12'h000);
    check(valid, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      w = word(i[1:0]);
      frame(w, 16, 1'b1);
      if (i[1:0] == 2'h0) keep = w[11:0];
      check(mode, i[1:0]);
      check(pd, i[1:0] != 2'h0);
      check(val, keep);
      check(valid, i[1:0] == 2'h0);
    end
    frame(word(2'h1), 8, 1'b0);
    check(mode, 2'h0);
    frame(word(2'h2), 10, 1'b1);
    frame(16'h0000, 0, 1'b1);
    check(mode, 2'h0);
    check(val, keep);
    w = word(2'h0);
    frame(w, 16, 1'b1);
    check(val, w[11:0]);
    check(commits[15:0], 16'h0009);
    test_done;
  end
endmodule
`default_nettype wire
